/* File: hw/tars_map.svh */
`ifndef TARS_MAP_SVH
`define TARS_MAP_SVH

// System clock period and the tenth-second time base
`define TARS_CLK_PERIOD_NS        4
`define TARS_TENTH_NS             100000000
`define TARS_TENTH_CYCLES         (`TARS_TENTH_NS / `TARS_CLK_PERIOD_NS)

// Trip-free running period, lower bound, in seconds
`define TARS_TRIP_FREE_MIN_S      300
`define TARS_TENTHS_PER_S         10
`define TARS_FREE_DELAY_MULT      4

// Delay setting range, in tenths of a second
`define TARS_DELAY_MAX_TENTHS     13'h1770
`define TARS_DELAY_RST            13'h0000

// Attempt limit range and reset values
`define TARS_ATTEMPTS_MIN         4'h1
`define TARS_ATTEMPTS_MAX         4'hA
`define TARS_ATTEMPTS_RST         4'h5

// Trigger mask reset value
`define TARS_MASK_RST             16'h0000

`endif

/* File: hw/tars_pkg.sv */
package tars_pkg;

    // Delay in tenths of a second, up to 600.0 s
    typedef logic [12:0] tars_tenths_t;
    // Attempt counts
    typedef logic [3:0]  tars_count_t;
    // Trip-free period in tenths, up to four times the longest delay
    typedef logic [14:0] tars_free_t;

    // Four 16-bit trigger words of one set
    typedef struct packed {
        logic [3:0][15:0] word;
    } tars_mask_s;

    // Delay pair of one trigger set
    typedef struct packed {
        tars_tenths_t initial_dly;
        tars_tenths_t between_dly;
    } tars_delay_s;

    // Status toward configuration side
    typedef struct packed {
        logic         pending;
        logic         restarting;
        tars_count_t  attempts_left;
        tars_tenths_t time_left;
    } tars_status_s;

    typedef enum logic [1:0] {
        st_idle,
        st_wait_clear,
        st_delay,
        st_lockout
    } tars_state_e;

endpackage

/* File: hw/tars_tenth_timer.sv */
`include "tars_map.svh"

module tars_tenth_timer #(
    parameter int unsigned TICK_CYCLES = `TARS_TENTH_CYCLES
) (
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic             load,
    input  wire tars_pkg::tars_tenths_t load_val,
    output logic                  tick,
    output tars_pkg::tars_tenths_t remain
);
    import tars_pkg::*;

    localparam int PW = $clog2(TICK_CYCLES + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

    logic [PW-1:0] pre_ff;
    logic [PW-1:0] nxt_pre;
    logic          tick_ff;
    logic          nxt_tick;
    tars_tenths_t  remain_ff;
    tars_tenths_t  nxt_remain;

    // Prescaler restarts on load so a delay is never cut short by a stale phase
    always_comb begin
        nxt_pre    = pre_ff + PW'(1);
        nxt_tick   = 1'b0;
        nxt_remain = remain_ff;
        if (load || pre_ff == PRE_LAST) begin
            nxt_pre = '0;
        end
        if (pre_ff == PRE_LAST && !load) begin
            nxt_tick = 1'b1;
        end
        if (load) begin
            nxt_remain = load_val;
        end else if (tick_ff && remain_ff != '0) begin
            nxt_remain = remain_ff - 13'h0001;
        end
    end

    // Register stage
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pre_ff    <= '0;
            tick_ff   <= 1'b0;
            remain_ff <= `TARS_DELAY_RST;
        end else begin
            pre_ff    <= nxt_pre;
            tick_ff   <= nxt_tick;
            remain_ff <= nxt_remain;
        end
    end

    assign tick   = tick_ff;
    assign remain = remain_ff;

endmodule // tars_tenth_timer

/* File: hw/tars_sequencer.sv */
// Contract
// R1: Restarts are scheduled and issued only while the enable input is true.
// R2: Attempt limit is settable from 1 to 10, default 5.
// R3: With no attempts left, retrying stops until an external trip reset.
// R4: Count clears after trip-free running of max(5 min, 4x set one between delay).
// R5: Count clears on trip reset, run request removal or enable false.
// R6: Set one trips use set one initial then between-attempt delay.
// R7: Every restart delay is timed from all errors clearing.
// R8: Delay settings span 0.0 to 600.0 s in tenth-second steps.
// R9: Set-two-only trips use set two initial and between delays.
// R10: Each set is four 16-bit masks, default zero, a bit enables a trip.
// R11: A trip in both sets uses set one delays.
// R12: Pending flag is high while a restart waits for its delay.
// R13: Restart strobe is high for exactly one cycle.
// R14: Attempts remaining is reported and reads 5 after reset.
// R15: Remaining delay is reported in tenths while waiting.
// R16: A running nonzero countdown ignores later delay setting changes.
// R17: Each restart decrements attempts left; clearing reloads from the limit.
`include "tars_map.svh"

module tars_sequencer #(
    parameter int unsigned TICK_CYCLES = `TARS_TENTH_CYCLES
) (
    input  wire logic                  clk_sys,
    input  wire logic                  sys_rst,
    input  wire logic                  auto_enable,
    input  wire tars_pkg::tars_count_t attempts_limit,
    input  wire tars_pkg::tars_delay_s set_one_delay,
    input  wire tars_pkg::tars_delay_s set_two_delay,
    input  wire tars_pkg::tars_mask_s  set_one_trip_mask,
    input  wire tars_pkg::tars_mask_s  set_two_trip_mask,
    input  wire logic                  trip_active,
    input  wire logic [63:0]           trip_flags,
    input  wire logic                  error_present,
    input  wire logic                  run_request,
    input  wire logic                  trip_reset,
    output tars_pkg::tars_status_s     status
);
    import tars_pkg::*;

    // Clamp a delay setting to 600.0 s
    function automatic tars_tenths_t clamp_delay(input tars_tenths_t d);
        clamp_delay = (d > `TARS_DELAY_MAX_TENTHS) ? `TARS_DELAY_MAX_TENTHS : d;
    endfunction

    // Clamp the attempt limit into 1..10
    function automatic tars_count_t clamp_limit(input tars_count_t n);
        if (n < `TARS_ATTEMPTS_MIN) begin
            clamp_limit = `TARS_ATTEMPTS_MIN;
        end else if (n > `TARS_ATTEMPTS_MAX) begin
            clamp_limit = `TARS_ATTEMPTS_MAX;
        end else begin
            clamp_limit = n;
        end
    endfunction

    // Pick the delay for the attempt at hand
    function automatic tars_tenths_t pick_delay(input logic use_one,
                                                input logic first);
        tars_delay_s d;
        d = use_one ? set_one_delay : set_two_delay; // R11
        pick_delay = clamp_delay(first ? d.initial_dly : d.between_dly); // R8
    endfunction

    localparam tars_free_t FREE_MIN =
        15'(`TARS_TRIP_FREE_MIN_S * `TARS_TENTHS_PER_S);

    tars_state_e  state_ff;
    tars_state_e  nxt_state;
    logic         use_one_ff;
    logic         nxt_use_one;
    logic         first_ff;
    logic         nxt_first;
    logic         trip_q_ff;
    tars_free_t   free_ff;
    tars_free_t   nxt_free;
    tars_status_s status_ff;
    tars_status_s nxt_status;

    logic         tick;
    tars_tenths_t remain;
    logic         load;
    tars_tenths_t load_val;
    logic         restart;
    logic         hit_one;
    logic         hit_two;
    logic         abort;
    logic         free_done;
    logic         clear_count;
    tars_count_t  limit;
    tars_free_t   free_thresh;
    tars_free_t   free_scaled;

    // Tick prescaler and countdown; latched value keeps R16 by construction
    tars_tenth_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timer (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .load     (load),
        .load_val (load_val), // R16
        .tick     (tick),
        .remain   (remain)
    );

    // Trigger selection and clear conditions
    always_comb begin
        hit_one     = |(trip_flags & set_one_trip_mask.word); // R10
        hit_two     = |(trip_flags & set_two_trip_mask.word); // R10
        limit       = clamp_limit(attempts_limit); // R2
        abort       = !auto_enable || !run_request || trip_reset; // R1 R5
        free_scaled = 15'(clamp_delay(set_one_delay.between_dly)) *
                      15'(`TARS_FREE_DELAY_MULT);
        free_thresh = (free_scaled > FREE_MIN) ? free_scaled : FREE_MIN; // R4
        free_done   = free_ff >= free_thresh;
        clear_count = abort || free_done; // R4 R5
    end

    // Trip-free running timer, counted only while idle and running clean
    always_comb begin
        nxt_free = free_ff;
        if (state_ff != st_idle || !run_request || trip_active || abort) begin
            nxt_free = '0;
        end else if (tick && !free_done) begin
            nxt_free = free_ff + 15'h0001; // R4
        end
    end

    // Sequencer state machine
    always_comb begin
        nxt_state   = state_ff;
        nxt_use_one = use_one_ff;
        nxt_first   = first_ff;
        load        = 1'b0;
        load_val    = '0;
        restart     = 1'b0;
        if (abort) begin
            nxt_state = st_idle; // R1
        end else begin
            case (state_ff)
                st_idle: begin
                    // Only a fresh trip arms a restart, so a lingering
                    // trip after a strobe cannot re-arm by itself
                    if (trip_active && !trip_q_ff && (hit_one || hit_two)) begin
                        if (status_ff.attempts_left == '0) begin
                            nxt_state = st_lockout; // R3
                        end else begin
                            nxt_use_one = hit_one; // R11
                            nxt_first   = status_ff.attempts_left == limit;
                            nxt_state   = st_wait_clear;
                        end
                    end
                end
                st_wait_clear: begin
                    if (!error_present) begin
                        load      = 1'b1; // R7
                        load_val  = pick_delay(use_one_ff, first_ff); // R6 R9
                        nxt_state = st_delay;
                    end
                end
                st_delay: begin
                    if (error_present) begin
                        nxt_state = st_wait_clear; // R7
                    end else if (remain == '0) begin
                        restart   = 1'b1; // R13
                        nxt_state = st_idle;
                    end
                end
                st_lockout: begin
                    nxt_state = st_lockout; // R3
                end
                default: begin
                    nxt_state = st_idle;
                end
            endcase
        end
    end

    // Status outputs and attempt bookkeeping
    always_comb begin
        nxt_status            = status_ff;
        nxt_status.restarting = restart; // R13
        nxt_status.pending    = nxt_state == st_wait_clear ||
                                nxt_state == st_delay; // R12
        nxt_status.time_left  = (state_ff == st_delay) ? remain : '0; // R15
        if (clear_count) begin
            nxt_status.attempts_left = limit; // R17
        end else if (restart) begin
            nxt_status.attempts_left = status_ff.attempts_left - 4'h1; // R17
        end
    end

    // Register stage
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_ff   <= st_idle;
            use_one_ff <= 1'b0;
            first_ff   <= 1'b0;
            trip_q_ff  <= 1'b0;
            free_ff    <= '0;
            status_ff  <= '{pending: 1'b0, restarting: 1'b0,
                           attempts_left: `TARS_ATTEMPTS_RST, // R14
                           time_left: `TARS_DELAY_RST};
        end else begin
            state_ff   <= nxt_state;
            use_one_ff <= nxt_use_one;
            first_ff   <= nxt_first;
            trip_q_ff  <= trip_active;
            free_ff    <= nxt_free;
            status_ff  <= nxt_status;
        end
    end

    assign status = status_ff;

    // Checks on the design's own behaviour
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence s_delay_done;
        state_ff == st_delay && remain == '0 && !error_present && !abort;
    endsequence

    sequence s_one_strobe;
        status_ff.restarting ##1 !status_ff.restarting;
    endsequence

    a_strobe_one_cycle: assert property ( // R13
        s_delay_done |=> s_one_strobe)
        else $error("restart strobe not a single cycle after delay end");

    a_no_restart_off: assert property ( // R1
        !auto_enable |=> !status_ff.restarting && !status_ff.pending)
        else $error("restart activity while disabled");

    a_left_decrement: assert property ( // R17
        status_ff.restarting |-> status_ff.attempts_left ==
            $past(status_ff.attempts_left) - 4'h1)
        else $error("attempts left not decremented on restart");

    a_lockout_holds: assert property ( // R3
        state_ff == st_lockout && !abort |=>
            state_ff == st_lockout && !status_ff.restarting)
        else $error("lockout left without external reset");

    a_pending_first: assert property ( // R12
        status_ff.restarting |-> $past(status_ff.pending))
        else $error("restart without prior pending");

    a_count_cleared: assert property ( // R5
        !run_request || trip_reset |=>
            status_ff.attempts_left == $past(limit) && !status_ff.pending)
        else $error("attempt count not cleared");

    a_free_clear: assert property ( // R4
        free_done && state_ff == st_idle |=>
            status_ff.attempts_left == $past(limit))
        else $error("trip-free period did not clear count");

    a_set_one_delay: assert property ( // R6
        load && use_one_ff |-> load_val == clamp_delay(first_ff ?
            set_one_delay.initial_dly : set_one_delay.between_dly))
        else $error("set one delay not applied");

    a_set_two_delay: assert property ( // R9
        load && !use_one_ff |-> load_val == clamp_delay(first_ff ?
            set_two_delay.initial_dly : set_two_delay.between_dly))
        else $error("set two delay not applied");

    a_both_sets_one: assert property ( // R11
        state_ff == st_idle && !abort && trip_active && !trip_q_ff &&
            hit_one && hit_two && status_ff.attempts_left != '0
            |=> use_one_ff)
        else $error("set one lost priority");

    a_load_clear: assert property ( // R7
        load |-> !error_present ##1 state_ff == st_delay &&
            remain == $past(load_val))
        else $error("delay not started on error clearing");

    a_delay_range: assert property ( // R8
        status_ff.time_left <= `TARS_DELAY_MAX_TENTHS)
        else $error("time left above maximum");

    a_time_follows: assert property ( // R15
        state_ff == st_delay |=> status_ff.time_left == $past(remain))
        else $error("time left does not track countdown");

    a_count_frozen: assert property ( // R16
        state_ff == st_delay && !load && !tick && !error_present &&
            remain != '0 |=> remain == $past(remain))
        else $error("countdown moved without a tick");

    a_left_bound: assert property ( // R14
        status_ff.attempts_left <= `TARS_ATTEMPTS_MAX)
        else $error("attempts left above limit");

    a_wait_errors: assert property ( // R7
        state_ff == st_wait_clear && error_present |=>
            state_ff != st_delay)
        else $error("delay started with errors present");

    a_mask_needed: assert property ( // R10
        state_ff == st_idle && !hit_one && !hit_two |=> state_ff == st_idle)
        else $error("restart armed by an unselected trip");

endmodule // tars_sequencer

/* File: bench/tars_drive_model.sv */
// Behavioural trip and error sequencing logic on the far side of the block
module tars_drive_model #(
    parameter int ERR_HOLD = 40
) (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        fire,
    input  wire logic [63:0] fire_flags,
    input  wire logic        clear_trip,
    input  wire logic        restarting,
    output logic             trip_active,
    output logic [63:0]      trip_flags,
    output logic             error_present
);
    timeunit 1ns;
    timeprecision 1ps;

    int err_cnt;

    // Errors outlast the trip edge so delays must start at clearing
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            trip_active   <= 1'b0;
            trip_flags    <= 64'h0;
            error_present <= 1'b0;
            err_cnt       <= 0;
        end else if (fire) begin
            trip_active   <= 1'b1;
            trip_flags    <= fire_flags;
            error_present <= 1'b1;
            err_cnt       <= ERR_HOLD;
        end else begin
            if (err_cnt != 0) err_cnt <= err_cnt - 1;
            else error_present <= 1'b0;
            // Trip drops on restart or on an external reset
            if (restarting || clear_trip) begin
                trip_active <= 1'b0;
                trip_flags  <= 64'h0;
            end
        end
    end
endmodule // tars_drive_model

/* File: bench/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tars_pkg::*;

    localparam int TICK = 4;
    logic clk_sys, sys_rst, auto_enable, run_request, trip_reset;
    logic fire, clear_trip, trip_active, error_present;
    logic [63:0] fire_flags, trip_flags;
    tars_count_t attempts_limit;
    tars_delay_s set_one_delay, set_two_delay;
    tars_mask_s set_one_trip_mask, set_two_trip_mask;
    tars_status_s status;
    int n_fail, comparisons, cyc;

    tars_sequencer #(.TICK_CYCLES(TICK)) u_tars_sequencer (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .auto_enable(auto_enable),
        .attempts_limit(attempts_limit), .set_one_delay(set_one_delay),
        .set_two_delay(set_two_delay), .set_one_trip_mask(set_one_trip_mask),
        .set_two_trip_mask(set_two_trip_mask), .trip_active(trip_active),
        .trip_flags(trip_flags), .error_present(error_present),
        .run_request(run_request), .trip_reset(trip_reset), .status(status));

    tars_drive_model u_tars_drive_model (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .fire(fire),
        .fire_flags(fire_flags), .clear_trip(clear_trip),
        .restarting(status.restarting), .trip_active(trip_active),
        .trip_flags(trip_flags), .error_present(error_present));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %0h expected %0h",
                     $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Hang guard, sized well above the longest trip-free wait
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    // One trip: count cycles from errors clearing to the strobe
    task automatic run_trip(input logic [63:0] f, input int d,
                            input logic exp, input logic [3:0] left,
                            input logic poke);
        int n;
        int w;
        logic [12:0] mx;
        @(posedge clk_sys);
        fire <= 1'b1;
        fire_flags <= f;
        @(posedge clk_sys);
        fire <= 1'b0;
        #1;
        n = 0;
        while (error_present !== 1'b0 && n < 200) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        n = 0;
        w = 0;
        mx = 13'h0000;
        while (status.restarting !== 1'b1 && n < (exp ? 400 : 100)) begin
            @(posedge clk_sys);
            // Setting change mid-countdown must not move the strobe
            if (poke && n == d * TICK / 2)
                set_one_delay.between_dly <= 13'h0028;
            #1;
            n++;
            if (status.pending === 1'b1) w++;
            if (status.time_left > mx) mx = status.time_left;
        end
        if (exp) begin
            check(32'(n >= d * TICK + 2 && n <= d * TICK + 6), 32'h1);
            check(32'(w), 32'(n - 1));
            check(32'(mx), 32'(d));
            check(32'(status.attempts_left), 32'(left));
            @(posedge clk_sys);
            #1;
            check(32'(status.restarting), 32'h0);
        end else begin
            check(32'(w + (status.restarting === 1'b1)), 32'h0);
            @(posedge clk_sys);
            clear_trip <= 1'b1;
            @(posedge clk_sys);
            clear_trip <= 1'b0;
        end
    endtask

    // Drop run, drop enable or pulse trip reset for one cycle
    task automatic clear_pulse(input int k, input logic [3:0] exp);
        @(posedge clk_sys);
        case (k)
            0: run_request <= 1'b0;
            1: auto_enable <= 1'b0;
            default: trip_reset <= 1'b1;
        endcase
        @(posedge clk_sys);
        run_request <= 1'b1;
        auto_enable <= 1'b1;
        trip_reset <= 1'b0;
        @(posedge clk_sys);
        #1;
        check(32'(status.attempts_left), 32'(exp));
    endtask

    initial begin
        n_fail = 0;
        comparisons = 0;
        cyc = 0;
        sys_rst <= 1'b1;
        auto_enable <= 1'b0;
        run_request <= 1'b0;
        trip_reset <= 1'b0;
        fire <= 1'b0;
        clear_trip <= 1'b0;
        fire_flags <= 64'h0;
        attempts_limit <= 4'h5;
        set_one_delay <= '{initial_dly: 13'h0003, between_dly: 13'h0006};
        set_two_delay <= '{initial_dly: 13'h0009, between_dly: 13'h000C};
        set_one_trip_mask <= tars_mask_s'(64'h8000_0000_0000_0005);
        set_two_trip_mask <= tars_mask_s'(64'h0000_0000_0000_0006);
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        #1;
        check(32'(status), 32'h0000A000);
        @(posedge clk_sys);
        auto_enable <= 1'b1;
        run_request <= 1'b1;
        // Set one: initial then between, with a setting change in flight
        run_trip(64'h1, 3, 1'b1, 4'h4, 1'b0);
        run_trip(64'h8000_0000_0000_0000, 6, 1'b1, 4'h3, 1'b1);
        set_one_delay.between_dly <= 13'h0006;
        clear_pulse(2, 4'h5);
        // Set two only, then a trip in both sets
        run_trip(64'h2, 9, 1'b1, 4'h4, 1'b0);
        run_trip(64'h2, 12, 1'b1, 4'h3, 1'b0);
        clear_pulse(2, 4'h5);
        run_trip(64'h4, 3, 1'b1, 4'h4, 1'b0);
        run_trip(64'h8, 0, 1'b0, 4'h4, 1'b0);
        for (int k = 0; k < 2; k++) begin
            clear_pulse(k, 4'h5);
            run_trip(64'h1, 3, 1'b1, 4'h4, 1'b0);
        end
        // Disabled: nothing scheduled
        @(posedge clk_sys);
        auto_enable <= 1'b0;
        run_trip(64'h1, 0, 1'b0, 4'h5, 1'b0);
        // Limit of one: the second trip is locked out
        attempts_limit <= 4'h1;
        clear_pulse(2, 4'h1);
        run_trip(64'h1, 3, 1'b1, 4'h0, 1'b0);
        run_trip(64'h1, 0, 1'b0, 4'h0, 1'b0);
        attempts_limit <= 4'hA;
        clear_pulse(2, 4'hA);
        attempts_limit <= 4'h5;
        clear_pulse(2, 4'h5);
        // Trip-free running clears the count at the longer period
        for (int i = 0; i < 2; i++) begin
            set_one_delay.between_dly <= 13'h0006;
            run_trip(64'h1, 3, 1'b1, 4'h4, 1'b0);
            if (i == 1) set_one_delay.between_dly <= 13'h03E8;
            repeat (((i == 1 ? 4000 : 3000) - 200) * TICK) @(posedge clk_sys);
            #1;
            check(32'(status.attempts_left), 32'h4);
            repeat (400 * TICK) @(posedge clk_sys);
            #1;
            check(32'(status.attempts_left), 32'h5);
        end
        tally_and_finish();
    end
endmodule // tb
